// >>> gt_pkg.sv
// package: constants for the gated 16-bit timer and its controller
// Notes on behaviour
// (R1) go bit arms; count from next gate edge
// (R2) trailing gate edge clears go; then ignore gate
// (R3) clearing single-pulse enable also clears go
// (R4) gate level status always shows current gate; the code shows the gate after polarity, toggle and single-pulse logic
// (R5) gate level falling edge sets gate flag
// (R6) gate flag works with gate control off
// (R7) count wraps FFFF to 0000, sets overflow
// (R8) overflow irq needs on, enables; software clears
// (R9) sleep counting only unsynchronised external source
// (R10) overflow in sleep wakes; vectors if global
// (R11) capture copies count into capcmp pair
// (R12) compare event when capcmp equals count
// (R13) compare trigger clears count, no overflow flag
// (R14) software picks synced Fosc/4 for triggers
// (R15) count write beats simultaneous trigger clear
// (R16) prescale field divides by 1/2/4/8
// (R17) sync bit ignored for system clock sources
// (R18) wide mode makes 16-bit count access atomic
// (R19) timer on enables; off clears toggle flop
// (R20) gate enable qualifies counting while on
// (R21) gate polarity picks counting gate level
// (R22) four-bit clock select chooses count source
// (R23) toggle mode flop inverts on gate edge
// (R24) low read latches high; high write buffered
`default_nettype none
package gt_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// device register indices
	localparam logic [3:0] A_TCON = 4'h0;
	localparam logic [3:0] A_GCON = 4'h1;
	localparam logic [3:0] A_CLK = 4'h2;
	localparam logic [3:0] A_CLO = 4'h3;
	localparam logic [3:0] A_CHI = 4'h4;
	localparam logic [3:0] A_CCL = 4'h5;
	localparam logic [3:0] A_CCH = 4'h6;
	localparam logic [3:0] A_FLAG = 4'h7;
	localparam logic [3:0] A_IEN = 4'h8;
	// timer_control fields
	localparam int TC_ON = 0;
	localparam int TC_WIDE = 1;
	localparam int TC_SYNC = 2;
	localparam int TC_PS = 4;
	// gate_control fields
	localparam int GC_GO = 3;
	localparam int GC_SPM = 4;
	localparam int GC_GTM = 5;
	localparam int GC_POL = 6;
	localparam int GC_GE = 7;
	// flag and enable fields
	localparam int FL_OVF = 0;
	localparam int FL_GEV = 1;
	localparam int EN_PER = 6;
	localparam int EN_GLB = 7;
	// clock select codes
	localparam logic [3:0] CS_FOSC4 = 4'h1;
	localparam logic [3:0] CS_FOSC = 4'h2;
	localparam logic [3:0] CS_RSV = 4'hE;
	localparam logic [1:0] FOSC4_LAST = 2'h3;
	localparam logic [2:0] PS_MASK [0:3] = '{3'h0, 3'h1, 3'h3, 3'h7};
	// controller register byte offsets
	localparam logic [3:0] C_CMD = 4'h0;
	localparam logic [3:0] C_STAT = 4'h4;
	localparam logic [3:0] C_PER = 4'h8;
	localparam int CMD_A = 8;
	localparam int CMD_RD = 12;
	localparam int ST_BUSY = 8;
	localparam int PR_SLEEP = 0;
	localparam int PR_CAP = 1;
	localparam int PR_CMP = 2;
	localparam int PR_TRIG = 3;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
endpackage
`default_nettype wire

// >>> gt_if.sv
// interface: register port and peripheral signals between the two ends
`timescale 1ns/1ns
`default_nettype none
interface gt_if;
	logic [3:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	logic [15:0] src;
	logic gate;
	logic sleep;
	logic cap_event;
	logic cap_mode;
	logic cmp_mode;
	logic trig_en;
	modport dev (input addr, wr, rd, wdata, src, gate, sleep, cap_event,
		cap_mode, cmp_mode, trig_en, output rdata, rvalid);
	modport ctl (output addr, wr, rd, wdata, src, gate, sleep, cap_event,
		cap_mode, cmp_mode, trig_en, input rdata, rvalid);
endinterface
`default_nettype wire

// >>> gt_edge.sv
// edge finder with optional two-flop synchroniser
`timescale 1ns/1ns
`default_nettype none
module gt_edge (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic d_i,
	input wire logic sync_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic s1, s2, d1, prev;
	// s1 feeds only s2
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= 1'h0;
			s2 <= 1'h0;
			d1 <= 1'h0;
			prev <= 1'h0;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			d1 <= d_i;
			prev <= level_o;
		end
	end
	// pick path, then compare with last level
	assign level_o = sync_i ? s2 : d1;
	assign rise_o = level_o && !prev;
	assign fall_o = !level_o && prev;
endmodule // gt_edge
`default_nettype wire

// >>> gt_timer.sv
// gated 16-bit timer: device end
//
// Design decisions made here: the placing of the registers and the gt_if register port to them; the AXI4-Lite side is in gt_ctl.
`timescale 1ns/1ns
`default_nettype none
module gt_timer import gt_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	gt_if.dev bus,
	output logic irq_o,
	output logic wake_o,
	output logic compare_event_o
);
	logic [1:0] ps_sel;
	logic sync_off, wide, tmr_on;
	logic ge, gate_polarity, gate_toggle_enable, spm, go;
	logic [3:0] cs;
	logic [CNT_W-1:0] count, capcmp;
	logic [7:0] hi_hold, hi_buf, rd_val;
	logic ovf_flag, gev_flag, ovf_en, gev_en, per_en, glb_en;
	logic [1:0] q4;
	logic [2:0] presc;
	logic pulse_on, gate_level_status, tff, gt_d, match_d;
	logic wr_tc, wr_gc, wr_cs, wr_lo, wr_hi, wr_cl, wr_ch, wr_fl, wr_en;
	logic rd_lo, cnt_wr, internal, src_rise, edge_in, awake_ok, tick, run;
	logic g_lvl, g_rise, g_fall, gp, gp_rise, gtm_lvl, gtm_rise, gtm_fall;
	logic gate_next, gev_hit, ovf_hit, match, cmp_pulse, trig_clr, ovf_req;

	// register strobes
	assign wr_tc = bus.wr && bus.addr == A_TCON;
	assign wr_gc = bus.wr && bus.addr == A_GCON;
	assign wr_cs = bus.wr && bus.addr == A_CLK;
	assign wr_lo = bus.wr && bus.addr == A_CLO;
	assign wr_hi = bus.wr && bus.addr == A_CHI;
	assign wr_cl = bus.wr && bus.addr == A_CCL;
	assign wr_ch = bus.wr && bus.addr == A_CCH;
	assign wr_fl = bus.wr && bus.addr == A_FLAG;
	assign wr_en = bus.wr && bus.addr == A_IEN;
	assign rd_lo = bus.rd && bus.addr == A_CLO;
	assign cnt_wr = wr_lo || (wr_hi && !wide); // [R18]

	// timer_control
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ps_sel <= 2'h0;
			sync_off <= 1'h0;
			wide <= 1'h0;
			tmr_on <= 1'h0;
		end else if (wr_tc) begin
			ps_sel <= bus.wdata[TC_PS+1:TC_PS];
			sync_off <= bus.wdata[TC_SYNC];
			wide <= bus.wdata[TC_WIDE];
			tmr_on <= bus.wdata[TC_ON];
		end
	end

	// gate_control writable bits and clock select
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ge <= 1'h0;
			gate_polarity <= 1'h0;
			gate_toggle_enable <= 1'h0;
			spm <= 1'h0;
			cs <= 4'h0;
		end else begin
			if (wr_gc) begin
				ge <= bus.wdata[GC_GE];
				gate_polarity <= bus.wdata[GC_POL];
				gate_toggle_enable <= bus.wdata[GC_GTM];
				spm <= bus.wdata[GC_SPM];
			end
			if (wr_cs) begin
				cs <= bus.wdata[3:0];
			end
		end
	end

	// interrupt enables
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ovf_en <= 1'h0;
			gev_en <= 1'h0;
			per_en <= 1'h0;
			glb_en <= 1'h0;
		end else if (wr_en) begin
			ovf_en <= bus.wdata[FL_OVF];
			gev_en <= bus.wdata[FL_GEV];
			per_en <= bus.wdata[EN_PER];
			glb_en <= bus.wdata[EN_GLB];
		end
	end

	// count source: system clock paths skip the synchroniser
	assign internal = (cs == CS_FOSC) || (cs == CS_FOSC4);
	gt_edge u_src (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(bus.src[cs]),
		.sync_i(!sync_off), // [R17]
		.level_o(),
		.rise_o(src_rise),
		.fall_o()
	);
	assign edge_in = (cs == CS_FOSC) ? 1'h1 :
		(cs == CS_FOSC4) ? (q4 == FOSC4_LAST) :
		(cs >= CS_RSV) ? 1'h0 : src_rise; // [R22]
	// asleep, only an unsynchronised outside source keeps running
	assign awake_ok = !bus.sleep || (sync_off && !internal); // [R9]
	assign tick = edge_in && awake_ok &&
		((presc & PS_MASK[ps_sel]) == PS_MASK[ps_sel]); // [R16]
	assign run = tmr_on && (!ge || gate_level_status) && tick; // [R19] [R20]

	// free-running quarter-rate strobe; prescaler cleared by count writes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q4 <= 2'h0;
			presc <= 3'h0;
		end else begin
			q4 <= q4 + 2'h1;
			if (cnt_wr) begin
				presc <= 3'h0;
			end else if (edge_in && awake_ok && tmr_on) begin
				presc <= presc + 3'h1;
			end
		end
	end

	// gate input, polarity and toggle flop
	gt_edge u_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(bus.gate),
		.sync_i(1'h0),
		.level_o(g_lvl),
		.rise_o(g_rise),
		.fall_o(g_fall)
	);
	assign gp = gate_polarity ? g_lvl : !g_lvl; // [R21]
	assign gp_rise = gate_polarity ? g_rise : g_fall;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tff <= 1'h0;
		end else if (!gate_toggle_enable || !tmr_on) begin
			tff <= 1'h0; // [R19] [R23]
		end else if (gp_rise) begin
			tff <= !tff; // [R23]
		end
	end
	assign gtm_lvl = gate_toggle_enable ? tff : gp;
	assign gtm_rise = gtm_lvl && !gt_d;
	assign gtm_fall = !gtm_lvl && gt_d;

	// single-pulse window follows one gate pulse after arming
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gt_d <= 1'h0;
			pulse_on <= 1'h0;
		end else begin
			gt_d <= gtm_lvl;
			if (!spm) begin
				pulse_on <= 1'h0;
			end else if (go && gtm_rise) begin
				pulse_on <= 1'h1; // [R1]
			end else if (gtm_fall) begin
				pulse_on <= 1'h0;
			end
		end
	end

	// acquisition go bit: software write wins over hardware clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			go <= 1'h0;
		end else if (wr_gc) begin
			go <= bus.wdata[GC_GO] && bus.wdata[GC_SPM]; // [R3]
		end else if (!spm) begin
			go <= 1'h0; // [R3]
		end else if (pulse_on && gtm_fall) begin
			go <= 1'h0; // [R2]
		end
	end

	// gate level seen by the counter
	assign gate_next = spm ? pulse_on : gtm_lvl; // [R2]
	assign gev_hit = gate_level_status && !gate_next; // [R5] [R6]
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_level_status <= 1'h0;
		end else begin
			gate_level_status <= gate_next; // [R4]
		end
	end

	// compare match and trigger clear
	assign match = count == capcmp; // [R12]
	assign cmp_pulse = bus.cmp_mode && match && !match_d;
	assign trig_clr = cmp_pulse && bus.trig_en;
	assign ovf_hit = run && count == CNT_MAX && !cnt_wr && !trig_clr;

	// count register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= CNT_ZERO;
		end else if (wr_lo) begin
			count <= {wide ? hi_buf : count[15:8], bus.wdata}; // [R15] [R24]
		end else if (wr_hi && !wide) begin
			count[15:8] <= bus.wdata; // [R15] [R18]
		end else if (trig_clr) begin
			count <= CNT_ZERO; // [R13]
		end else if (run) begin
			count <= count + CNT_ONE; // [R7]
		end
	end

	// byte pairing for wide access
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hi_hold <= 8'h00;
			hi_buf <= 8'h00;
		end else begin
			if (rd_lo) begin
				hi_hold <= count[15:8]; // [R24]
			end
			if (wr_hi) begin
				hi_buf <= bus.wdata; // [R24]
			end
		end
	end

	// capture/compare pair
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			capcmp <= CNT_ZERO;
			match_d <= 1'h0;
		end else begin
			match_d <= match;
			if (bus.cap_mode && bus.cap_event) begin
				capcmp <= count; // [R11]
			end else if (wr_cl) begin
				capcmp[7:0] <= bus.wdata;
			end else if (wr_ch) begin
				capcmp[15:8] <= bus.wdata;
			end
		end
	end

	// sticky flags: a new event beats a clearing write
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ovf_flag <= 1'h0;
			gev_flag <= 1'h0;
		end else begin
			ovf_flag <= ovf_hit || (wr_fl ? bus.wdata[FL_OVF] : ovf_flag); // [R7]
			gev_flag <= gev_hit || (wr_fl ? bus.wdata[FL_GEV] : gev_flag); // [R5]
		end
	end

	// read data mux
	always_comb begin
		unique case (bus.addr)
			A_TCON: rd_val = {2'h0, ps_sel, 1'h0, sync_off, wide, tmr_on};
			A_GCON: rd_val = {ge, gate_polarity, gate_toggle_enable, spm, go, gate_level_status, 2'h0};
			A_CLK: rd_val = {4'h0, cs};
			A_CLO: rd_val = count[7:0];
			A_CHI: rd_val = wide ? hi_hold : count[15:8]; // [R18]
			A_CCL: rd_val = capcmp[7:0];
			A_CCH: rd_val = capcmp[15:8];
			A_FLAG: rd_val = {6'h00, gev_flag, ovf_flag};
			A_IEN: rd_val = {glb_en, per_en, 4'h0, gev_en, ovf_en};
			default: rd_val = 8'h00;
		endcase
	end

	// registered outputs
	assign ovf_req = ovf_flag && ovf_en && tmr_on && per_en;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus.rdata <= 8'h00;
			bus.rvalid <= 1'h0;
			irq_o <= 1'h0;
			wake_o <= 1'h0;
			compare_event_o <= 1'h0;
		end else begin
			bus.rvalid <= bus.rd;
			if (bus.rd) begin
				bus.rdata <= rd_val;
			end
			irq_o <= (ovf_req || (gev_flag && gev_en && per_en)) && glb_en; // [R8]
			wake_o <= ovf_req && bus.sleep; // [R10]
			compare_event_o <= cmp_pulse; // [R12]
		end
	end
endmodule // gt_timer
`default_nettype wire

// >>> gt_ctl.sv
// controller end: AXI4-Lite slave driving the timer register port
`timescale 1ns/1ns
`default_nettype none
module gt_ctl import gt_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [15:0] src_i,
	input wire logic gate_i,
	input wire logic cap_event_i,
	gt_if.ctl bus
);
	logic aw_held, w_held, busy;
	logic [3:0] aw_a;
	logic [31:0] w_d;
	logic [3:0] w_s;
	logic [7:0] rd_lat;
	logic [3:0] per;
	logic aw_hs, w_hs, b_hs, ar_hs, r_hs, do_wr, cmd_ok;
	logic next_aw_held, next_w_held;

	assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
	assign b_hs = s_axi_bvalid_o && s_axi_bready_i;
	assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
	assign r_hs = s_axi_rvalid_o && s_axi_rready_i;
	assign next_aw_held = (aw_held || aw_hs) && !b_hs;
	assign next_w_held = (w_held || w_hs) && !b_hs;
	assign do_wr = aw_held && w_held && !s_axi_bvalid_o;
	assign cmd_ok = aw_a == C_CMD && w_s[1:0] == 2'h3 && !busy;

	// write channels taken in either order, response after both
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'h0;
			w_held <= 1'h0;
			aw_a <= 4'h0;
			w_d <= 32'h00000000;
			w_s <= 4'h0;
			s_axi_awready_o <= 1'h0;
			s_axi_wready_o <= 1'h0;
			s_axi_bvalid_o <= 1'h0;
			s_axi_bresp_o <= RESP_OK;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready_o <= !next_aw_held;
			s_axi_wready_o <= !next_w_held;
			if (aw_hs) begin
				aw_a <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				w_d <= s_axi_wdata_i;
				w_s <= s_axi_wstrb_i;
			end
			if (b_hs) begin
				s_axi_bvalid_o <= 1'h0;
			end else if (do_wr) begin
				s_axi_bvalid_o <= 1'h1;
				s_axi_bresp_o <= (cmd_ok || aw_a == C_PER) ? RESP_OK : RESP_ERR;
			end
		end
	end

	// peripheral settings and device access engine
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			per <= 4'h0;
			busy <= 1'h0;
			rd_lat <= 8'h00;
			bus.addr <= 4'h0;
			bus.wdata <= 8'h00;
			bus.wr <= 1'h0;
			bus.rd <= 1'h0;
		end else begin
			bus.wr <= 1'h0;
			bus.rd <= 1'h0;
			if (do_wr && aw_a == C_PER && w_s[0]) begin
				per <= w_d[3:0];
			end
			if (do_wr && cmd_ok) begin
				bus.addr <= w_d[CMD_A+3:CMD_A];
				bus.wdata <= w_d[7:0]; // [R1]
				bus.wr <= !w_d[CMD_RD];
				bus.rd <= w_d[CMD_RD];
				busy <= w_d[CMD_RD];
			end else if (bus.rvalid) begin
				busy <= 1'h0;
				rd_lat <= bus.rdata;
			end
		end
	end

	// peripheral signals forwarded to the timer
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus.src <= 16'h0000;
			bus.gate <= 1'h0;
			bus.cap_event <= 1'h0;
			bus.sleep <= 1'h0;
			bus.cap_mode <= 1'h0;
			bus.cmp_mode <= 1'h0;
			bus.trig_en <= 1'h0;
		end else begin
			bus.src <= src_i;
			bus.gate <= gate_i;
			bus.cap_event <= cap_event_i;
			bus.sleep <= per[PR_SLEEP]; // [R9]
			bus.cap_mode <= per[PR_CAP];
			bus.cmp_mode <= per[PR_CMP];
			bus.trig_en <= per[PR_TRIG];
		end
	end

	// read channel, answer one cycle after address taken
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'h0;
			s_axi_rvalid_o <= 1'h0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= RESP_OK;
		end else begin
			s_axi_arready_o <= r_hs || (!s_axi_rvalid_o && !ar_hs);
			if (r_hs) begin
				s_axi_rvalid_o <= 1'h0;
			end else if (ar_hs) begin
				s_axi_rvalid_o <= 1'h1;
				s_axi_rresp_o <= RESP_OK;
				unique case (s_axi_araddr_i)
					C_CMD: s_axi_rdata_o <= 32'h00000000;
					C_STAT: s_axi_rdata_o <= {23'h000000, busy, rd_lat};
					C_PER: s_axi_rdata_o <= {28'h0000000, per};
					default: begin
						s_axi_rdata_o <= 32'h00000000;
						s_axi_rresp_o <= RESP_ERR;
					end
				endcase
			end
		end
	end
endmodule // gt_ctl
`default_nettype wire

// >>> gt_props.sv
// checker: register port properties between controller and timer
`timescale 1ns/1ns
`default_nettype none
module gt_props import gt_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic gate
);
	logic spm_off;
	logic pol_hi;
	logic [7:0] tcon_sh;
	logic [7:0] clk_sh;
	// shadows of the last control values written
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			spm_off <= 1'h1;
			pol_hi <= 1'h0;
			tcon_sh <= 8'h00;
			clk_sh <= 8'h00;
		end else if (wr) begin
			if (addr == A_GCON) begin
				spm_off <= !wdata[GC_SPM];
				pol_hi <= wdata[GC_POL] && !wdata[GC_GTM];
			end
			if (addr == A_TCON)
				tcon_sh <= wdata;
			if (addr == A_CLK)
				clk_sh <= wdata;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_rd_answer; rd |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered next cycle");
	property p_rv_cause; rvalid |-> $past(rd); endproperty
	a_rv_cause: assert property (p_rv_cause)
		else $error("read answer without a read");
	property p_rdata_hold; !rd |=> $stable(rdata); endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without a read");
	property p_one_access; wr |=> !wr && !rd; endproperty
	a_one_access: assert property (p_one_access)
		else $error("write strobe longer than one cycle");
	property p_tcon_back;
		rd && addr == A_TCON |=> rdata == ($past(tcon_sh) & 8'h37);
	endproperty
	a_tcon_back: assert property (p_tcon_back)
		else $error("timer_control read back wrong");
	property p_clk_back;
		rd && addr == A_CLK |=> rdata == ($past(clk_sh) & 8'h0F);
	endproperty
	a_clk_back: assert property (p_clk_back)
		else $error("count_clock_select read back wrong");
	property p_go_clear;
		rd && addr == A_GCON && spm_off |=> !rdata[GC_GO] && rdata[1:0] == 2'h0;
	endproperty
	a_go_clear: assert property (p_go_clear)
		else $error("go bit set without single pulse mode");
	property p_gate_level;
		rd && addr == A_GCON && pol_hi && spm_off && $stable(gate) &&
			gate == $past(gate, 2) && gate == $past(gate, 3)
			|=> rdata[2] == $past(gate);
	endproperty
	a_gate_level: assert property (p_gate_level)
		else $error("gate level status differs from gate");
	property p_unmapped; rd && addr > A_IEN |=> rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped index read not zero");
endmodule // gt_props
`default_nettype wire

// >>> gated_timer16_control_tb.sv
// testbench: controller and timer joined through the register interface
`timescale 1ns/1ns
`default_nettype none
module gated_timer16_control_tb import gt_pkg::*; ();
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, gate_i = 1'h0, cap_i = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [15:0] src_i = 16'h0;
	logic awready, wready, bvalid, arready, rvalid, irq_o, wake_o, cev;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, v;
	logic [1:0] qb[$];
	logic [33:0] qr[$];
	int n_fail = 0, total_checks = 0, cyc = 0, n_cev = 0, seed = 10;
	gt_if intf();
	gt_timer i_gt_timer (.clk_i(clk_i), .rst_i(rst_i), .bus(intf),
		.irq_o(irq_o), .wake_o(wake_o), .compare_event_o(cev));
	gt_ctl i_gt_ctl (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .src_i(src_i), .gate_i(gate_i),
		.cap_event_i(cap_i), .bus(intf));
	gt_props i_gt_props (.clk_i(clk_i), .rst_i(rst_i), .addr(intf.addr),
		.wr(intf.wr), .rd(intf.rd), .wdata(intf.wdata), .rdata(intf.rdata),
		.rvalid(intf.rvalid), .gate(intf.gate));
	// free running clock
	always #10 clk_i = ~clk_i;
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one write: address and data offered together, response awaited
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic ap, wp;
		@(posedge clk_i);
		qb.push_back(er);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		ap = 1'h1;
		wp = 1'h1;
		while (ap || wp) begin
			@(posedge clk_i);
			if (ap && awready) begin
				awvalid <= 1'h0;
				ap = 1'h0;
			end
			if (wp && wready) begin
				wvalid <= 1'h0;
				wp = 1'h0;
			end
		end
		while (!bvalid) @(posedge clk_i);
		bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [33:0] er);
		@(posedge clk_i);
		qr.push_back(er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		@(posedge clk_i);
		while (!arready) @(posedge clk_i);
		arvalid <= 1'h0;
		@(posedge clk_i);
		while (!rvalid) @(posedge clk_i);
		rready <= 1'h0;
	endtask
	// device register write and read through the command register
	task automatic dw(input logic [3:0] i, input logic [7:0] d);
		axi_wr(C_CMD, {19'h0, 1'h0, i, d}, 4'hF, RESP_OK);
	endtask
	task automatic dr(input logic [3:0] i, input logic [7:0] e);
		axi_wr(C_CMD, {19'h0, 1'h1, i, 8'h00}, 4'hF, RESP_OK);
		repeat (3) @(posedge clk_i);
		axi_rd(C_STAT, {RESP_OK, 24'h0, e});
	endtask
	task automatic per(input logic [31:0] d);
		axi_wr(C_PER, d, 4'hF, RESP_OK);
	endtask
	// response watcher, compare events and hang limit
	always @(posedge clk_i) begin
		cyc++;
		if (cev === 1'h1)
			n_cev++;
		if (bvalid && bready)
			check({32'h0, bresp}, {32'h0, qb.pop_front()});
		if (rvalid && rready)
			check({rresp, rdata}, qr.pop_front());
		if (cyc == 30000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (2) @(posedge clk_i);
		for (int i = 0; i <= 9; i++)
			if (i != 1)
				dr(i[3:0], 8'h00);
		axi_wr(4'hC, 32'h0, 4'hF, RESP_ERR);
		axi_wr(C_CMD, 32'h0, 4'h1, RESP_ERR);
		axi_rd(4'hC, {RESP_ERR, 32'h0});
		// every clock select and prescale code, random upper bits
		for (int i = 0; i < 16; i++) begin
			v = $random(seed);
			dw(A_CLK, {v[7:4], i[3:0]});
			dr(A_CLK, {4'h0, i[3:0]});
			dw(A_TCON, {v[7:6], i[1:0], v[3:0]});
			dr(A_TCON, {2'h0, i[1:0], 1'h0, v[2:0]});
		end
		// wrap from a preload near the top, interrupt fully enabled
		dw(A_TCON, 8'h00);
		dw(A_CLK, {4'h0, CS_FOSC});
		dw(A_CHI, 8'hFF);
		dw(A_CLO, 8'hF0);
		dw(A_FLAG, 8'h00);
		dw(A_IEN, 8'hC1);
		dw(A_TCON, 8'h01);
		repeat (30) @(posedge clk_i);
		check({33'h0, irq_o}, 34'h1);
		dr(A_FLAG, 8'h01);
		dw(A_FLAG, 8'h00);
		repeat (3) @(posedge clk_i);
		check({33'h0, irq_o}, 34'h0);
		// compare trigger makes capcmp the period
		dw(A_TCON, 8'h00);
		dw(A_CLO, 8'h00);
		dw(A_CHI, 8'h00);
		dw(A_CLK, {4'h0, CS_FOSC4});
		dw(A_CCL, 8'h08);
		dw(A_CCH, 8'h00);
		per(32'hC);
		dw(A_TCON, 8'h01);
		repeat (400) @(posedge clk_i);
		dr(A_FLAG, 8'h00);
		check({33'h0, n_cev > 8}, 34'h1);
		// capture of a stopped count
		dw(A_TCON, 8'h00);
		dw(A_CLO, 8'hCD);
		dw(A_CHI, 8'h0B);
		per(32'h2);
		cap_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		cap_i <= 1'h0;
		dr(A_CCL, 8'hCD);
		dr(A_CCH, 8'h0B);
		// wide access pairs the bytes, byte mode does not
		dw(A_TCON, 8'h02);
		dw(A_CHI, 8'h12);
		dw(A_CLO, 8'h34);
		dr(A_CLO, 8'h34);
		dr(A_CHI, 8'h12);
		dw(A_CHI, 8'h55);
		dr(A_CLO, 8'h34);
		dr(A_CHI, 8'h12);
		dw(A_TCON, 8'h00);
		dw(A_CHI, 8'hAB);
		dr(A_CHI, 8'hAB);
		// unsynchronised pin count wraps in sleep
		dw(A_CLK, 8'h00);
		dw(A_CHI, 8'hFF);
		dw(A_CLO, 8'hFE);
		dw(A_IEN, 8'h41);
		per(32'h1);
		dw(A_TCON, 8'h05);
		repeat (8) begin
			repeat (4) @(posedge clk_i);
			src_i[0] <= ~src_i[0];
		end
		repeat (6) @(posedge clk_i);
		check({33'h0, wake_o}, 34'h1);
		check({33'h0, irq_o}, 34'h0);
		per(32'h0);
		dw(A_TCON, 8'h00);
		// gate level and gate event with gating off
		dw(A_GCON, 8'h40);
		dw(A_FLAG, 8'h00);
		gate_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		dr(A_GCON, 8'h44);
		gate_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		dr(A_FLAG, 8'h02);
		// single pulse: arm, disarm, then one pulse clears go
		dw(A_GCON, 8'h58);
		dr(A_GCON, 8'h58);
		dw(A_GCON, 8'h40);
		dr(A_GCON, 8'h40);
		dw(A_GCON, 8'hD8);
		gate_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		dr(A_GCON, 8'hDC);
		gate_i <= 1'h0;
		repeat (6) @(posedge clk_i);
		dr(A_GCON, 8'hD0);
		end_sim();
	end
endmodule // gated_timer16_control_tb
`default_nettype wire
